//--- design/vid_ctrl.sv
`timescale 1ns/100ps
module vid_ctrl
    import vid_pkg::*;
(
    input  wire logic                        core_clk,
    input  wire logic                        rstn,
    input  wire vid_pkg::vid_bus_s           bus,
    input  wire logic                        chain_enable_in,
    output logic                             chain_enable_out,
    output logic                             irq_request_n,
    input  wire logic [vid_pkg::NUM_SRC-1:0] src_event,
    input  wire vid_pkg::vid_ctl_s           ctl,
    input  wire logic                        global_enable_set,
    input  wire logic                        global_enable_clr,
    input  wire logic                        block_lower_chain,
    input  wire logic                        no_vector,
    input  wire logic                        vector_with_status,
    input  wire logic [vid_pkg::VEC_W-1:0]   vector_base,
    output logic [vid_pkg::VEC_W-1:0]        low_bus_byte_out,
    output logic                             low_bus_byte_oe,
    output logic [vid_pkg::VEC_W-1:0]        poll_status,
    output logic                             global_enable,
    output logic [vid_pkg::NUM_SRC-1:0]      irq_pending,
    output logic [vid_pkg::NUM_SRC-1:0]      in_service
);
    import vid_pkg::*;

    // ==========================================
    // strobe edge detection
    vid_bus_s bus_q;
    logic     ack_flag;
    logic     drive_vec;
    logic [VEC_W-1:0] vec_q;
    logic [VEC_W-1:0] next_vec;
    logic [NUM_SRC-1:0] src_en_q;

    wire as_rise;
    wire ds_fall;
    wire ds_rise;

    assign as_rise = bus.addr_strobe_n && !bus_q.addr_strobe_n;
    assign ds_fall = !bus.data_strobe_n && bus_q.data_strobe_n;
    assign ds_rise = bus.data_strobe_n && !bus_q.data_strobe_n;

    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            bus_q <= '{1'b1, 1'b1, 1'b1};
        else
            bus_q <= bus;
    end

    // acknowledge flag held until the address strobe of the next transaction rises
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            ack_flag <= 1'b0;
        else if (as_rise)
            ack_flag <= !bus.ack_cycle_n;
    end

    // ==========================================
    // global enable
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            global_enable <= 1'b0;
            src_en_q      <= SRC_RESET;
        end
        else
        begin
            src_en_q <= ctl.source_enable;
            if (global_enable_set)
                global_enable <= 1'b1;
            else if (global_enable_clr)
                global_enable <= 1'b0;
        end
    end

    // ==========================================
    // source chain, highest priority first
    wire [NUM_SRC:0]   chain;
    wire [NUM_SRC-1:0] req;
    wire [NUM_SRC-1:0] sel;
    wire [NUM_SRC-1:0] eff_en;
    wire               ack_take;

    assign chain[0] = chain_enable_in;
    assign eff_en   = src_en_q & {NUM_SRC{global_enable}};
    assign ack_take = ack_flag && ds_fall;

    for (genvar i = 0; i < NUM_SRC; i++)
    begin : g_src
        vid_src u_src
        (
            .core_clk       (core_clk),
            .rstn           (rstn),
            .event_in       (src_event[i]),
            .clr_pending    (ctl.clr_pending[i]),
            .clr_in_service (ctl.clr_in_service[i]),
            .enable         (eff_en[i]),
            .ack_active     (ack_flag),
            .ack_take       (ack_take),
            .chain_in       (chain[i]),
            .chain_out      (chain[i+1]),
            .request        (req[i]),
            .selected       (sel[i]),
            .pending        (irq_pending[i]),
            .in_service     (in_service[i])
        );
    end

    // lower-chain block only gates the device output
    assign chain_enable_out = chain[NUM_SRC] && !block_lower_chain;
    assign irq_request_n    = ~|req;

    // ==========================================
    // vector output
    function automatic logic [SRC_W-1:0] enc_src(input logic [NUM_SRC-1:0] v);
        logic [SRC_W-1:0] r;
        r = '0;
        for (int k = NUM_SRC - 1; k >= 0; k--)
            if (v[k])
                r = SRC_W'(k);
        return r;
    endfunction

    wire [VEC_W-1:0] merged;
    wire             any_sel;

    assign any_sel = |sel;
    assign merged  = vector_with_status
                   ? ((vector_base & ~(VEC_W'({SRC_W{1'b1}}) << STAT_LSB))
                      | (VEC_W'(enc_src(sel)) << STAT_LSB))
                   : vector_base;
    assign next_vec = merged;

    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            vec_q     <= VEC_RESET;
            drive_vec <= 1'b0;
        end
        else if (ack_take && any_sel)
        begin
            vec_q     <= next_vec;
            drive_vec <= !no_vector;
        end
        else if (ds_rise || as_rise)
            drive_vec <= 1'b0;
    end

    assign low_bus_byte_out = vec_q;
    assign low_bus_byte_oe  = drive_vec;

    // ==========================================
    // poll register
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            poll_status <= POLL_NONE;
        else if (|irq_pending)
            poll_status <= POLL_FLAG | VEC_W'(enc_src(irq_pending));
        else
            poll_status <= POLL_NONE;
    end
endmodule

//--- design/vid_src.sv
`timescale 1ns/100ps
module vid_src
    import vid_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic rstn,
    input  wire logic event_in,
    input  wire logic clr_pending,
    input  wire logic clr_in_service,
    input  wire logic enable,
    input  wire logic ack_active,
    input  wire logic ack_take,
    input  wire logic chain_in,
    output logic      chain_out,
    output logic      request,
    output logic      selected,
    output logic      pending,
    output logic      in_service
);
    // ==========================================
    // state bits
    wire select_now;

    assign select_now = ack_take && pending && chain_in && enable && !in_service;
    assign selected   = select_now;

    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            pending    <= 1'b0;
            in_service <= 1'b0;
        end
        else
        begin
            // new event wins over a software clear
            pending    <= event_in || (pending && !clr_pending);
            in_service <= select_now || (in_service && !clr_in_service);
        end
    end

    // ==========================================
    // chain and request
    // in-service blocks regardless of enable
    assign chain_out = chain_in && !in_service
                       && !(ack_active && pending && enable);
    assign request   = pending && enable && !in_service && chain_in && !ack_active;
endmodule

//--- inc/vid_pkg.sv
package vid_pkg;

    // ==========================================
    // sizes
    localparam int NUM_SRC   = 4;
    localparam int SRC_W     = 2;
    localparam int VEC_W     = 8;
    // vector bits replaced by the source number when status is merged
    localparam int STAT_LSB  = 1;

    // ==========================================
    // reset values
    localparam logic [NUM_SRC-1:0] SRC_RESET = 4'h0;
    localparam logic [VEC_W-1:0]   VEC_RESET = 8'h00;
    localparam logic [VEC_W-1:0]   POLL_NONE = 8'h00;
    localparam logic [VEC_W-1:0]   POLL_FLAG = 8'h80;

    // ==========================================
    // bus strobe sample
    typedef struct packed {
        logic addr_strobe_n;
        logic data_strobe_n;
        logic ack_cycle_n;
    } vid_bus_s;

    // per-source software controls, one-cycle pulses except enables
    typedef struct packed {
        logic [NUM_SRC-1:0] source_enable;
        logic [NUM_SRC-1:0] clr_pending;
        logic [NUM_SRC-1:0] clr_in_service;
    } vid_ctl_s;

    typedef enum logic [1:0] {
        VID_IDLE,
        VID_ADDR,
        VID_ACK,
        VID_DATA
    } vid_bus_e;

endpackage

//--- sim/vid_ctrl_props.sv
`timescale 1ns/100ps
module vid_ctrl_props
    import vid_pkg::*;
(
    input wire logic              core_clk,
    input wire logic              rstn,
    input wire logic              chain_enable_in,
    input wire logic              chain_enable_out,
    input wire logic              irq_request_n,
    input wire logic [3:0]        src_event,
    input wire vid_pkg::vid_ctl_s ctl,
    input wire logic              block_lower_chain,
    input wire logic              no_vector,
    input wire logic              low_bus_byte_oe,
    input wire logic              global_enable,
    input wire logic [3:0]        irq_pending,
    input wire logic [3:0]        in_service
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    // ==========================================
    // chain and request
    a_lower_block: assert property (block_lower_chain |-> !chain_enable_out)
        else $error("chain out high while blocked");
    a_service_hold: assert property (|in_service |-> !chain_enable_out)
        else $error("chain out high while in service");
    a_chain_gate: assert property (!chain_enable_in |-> irq_request_n)
        else $error("request with chain in low");
    a_global_off: assert property (!global_enable |-> irq_request_n)
        else $error("request with global enable off");
    a_req_cause: assert property (!irq_request_n |-> |(irq_pending & ~in_service))
        else $error("request without pending source");
    // ==========================================
    // state bits and vector
    a_float_nv: assert property (no_vector |-> !low_bus_byte_oe)
        else $error("vector driven with no_vector set");
    a_event_set: assert property (|src_event |=> (irq_pending & $past(src_event))
        == $past(src_event)) else $error("event did not set pending");
    a_clear_pend: assert property (ctl.clr_pending[0] && !src_event[0] |=> !irq_pending[0])
        else $error("pending not cleared");
    a_service_set: assert property ($rose(low_bus_byte_oe)
        |-> $countones(in_service & ~$past(in_service)) == 1) else $error("no source taken");
endmodule
bind vid_ctrl vid_ctrl_props u_props (.core_clk, .rstn, .chain_enable_in, .chain_enable_out,
    .irq_request_n, .src_event, .ctl, .block_lower_chain, .no_vector, .low_bus_byte_oe,
    .global_enable, .irq_pending, .in_service);

//--- sim/vid_ctrl_tb_top.sv
`timescale 1ns/100ps
module vid_ctrl_tb_top;
    import vid_pkg::*;
    logic       core_clk, rstn, chain_enable_in, chain_enable_out, irq_request_n;
    logic       global_enable_set, global_enable_clr, block_lower_chain, no_vector;
    logic       vector_with_status, low_bus_byte_oe, global_enable;
    logic [3:0] src_event, irq_pending, in_service;
    logic [7:0] vector_base, low_bus_byte_out, poll_status;
    logic [8:0] got;
    vid_bus_s   bus;
    vid_ctl_s   ctl;
    int         bad_count, samples_checked;
    vid_ctrl u_dut (.core_clk, .rstn, .bus, .chain_enable_in, .chain_enable_out, .irq_request_n,
        .src_event, .ctl, .global_enable_set, .global_enable_clr, .block_lower_chain, .no_vector,
        .vector_with_status, .vector_base, .low_bus_byte_out, .low_bus_byte_oe, .poll_status,
        .global_enable, .irq_pending, .in_service);
    vid_host u_host (.core_clk, .bus, .oe(low_bus_byte_oe), .din(low_bus_byte_out));
    initial
    begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    // ==========================================
    // helpers
    task cyc(input int n); repeat (n) @(posedge core_clk); endtask
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task ev(input logic [3:0] m); src_event <= m; cyc(1); src_event <= 4'h0; cyc(2); endtask
    task clr(input logic [3:0] m);
        ctl.clr_pending <= m;
        ctl.clr_in_service <= m;
        cyc(1);
        ctl.clr_pending <= 4'h0;
        ctl.clr_in_service <= 4'h0;
        cyc(2);
    endtask
    task complete_run;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        cyc(4000);
        bad_count++;
        complete_run;
    end
    // ==========================================
    // tests
    initial
    begin
        {rstn, src_event, ctl, global_enable_set, global_enable_clr} = '0;
        {block_lower_chain, no_vector, vector_with_status} = '0;
        chain_enable_in = 1'b1;
        vector_base = 8'hA5;
        cyc(3);
        rstn <= 1'b1;
        cyc(1);
        chk({poll_status, irq_pending, in_service}, 16'h0000);
        chk({irq_request_n, global_enable, low_bus_byte_oe}, 16'h0004);
        $display("reset test done");
        ctl.source_enable <= 4'hF;
        ev(4'h4);
        chk({poll_status, irq_pending}, 16'h0824);
        chk(irq_request_n, 16'h0001);
        global_enable_set <= 1'b1;
        cyc(1);
        global_enable_set <= 1'b0;
        cyc(2);
        chk({chain_enable_out, irq_request_n}, 16'h0002);
        chain_enable_in <= 1'b0;
        cyc(1);
        chk({chain_enable_out, irq_request_n}, 16'h0001);
        chain_enable_in <= 1'b1;
        clr(4'hF);
        $display("request test done");
        for (int k = 0; k < 4; k++)
        begin
            vector_with_status <= k[0];
            ev(4'h1 << k);
            u_host.txn(1'b1, got);
            chk(got, {1'b1, k[0] ? {vector_base[7:3], k[1:0], vector_base[0]}
                                 : vector_base});
            chk({chain_enable_out, in_service}, 4'h1 << k);
            clr(4'hF);
            chk({irq_pending, in_service}, 16'h0000);
        end
        $display("vector test done");
        ev(4'hA);
        u_host.txn(1'b1, got);
        chk({irq_request_n, in_service}, 16'h0012);
        ev(4'h2);
        chk({irq_pending, in_service}, 16'h00A2);
        ctl.source_enable <= 4'hD;
        chain_enable_in <= 1'b0;
        cyc(2);
        chk({chain_enable_out, irq_request_n, in_service}, 16'h0012);
        chain_enable_in <= 1'b1;
        clr(4'h2);
        ctl.source_enable <= 4'hF;
        block_lower_chain <= 1'b1;
        cyc(2);
        // acknowledge flag from the last acknowledge still holds requests off
        chk({chain_enable_out, irq_request_n, irq_pending}, 16'h0018);
        block_lower_chain <= 1'b0;
        u_host.txn(1'b0, got);
        chk({got[8], in_service}, 16'h0000);
        chk({chain_enable_out, irq_request_n}, 16'h0002);
        no_vector <= 1'b1;
        u_host.txn(1'b1, got);
        chk({got[8], in_service}, 16'h0008);
        global_enable_clr <= 1'b1;
        cyc(1);
        global_enable_clr <= 1'b0;
        cyc(2);
        chk({global_enable, irq_request_n}, 16'h0001);
        $display("priority test done");
        complete_run;
    end
endmodule

//--- sim/vid_host.sv
`timescale 1ns/100ps
module vid_host
    import vid_pkg::*;
(
    input wire logic        core_clk,
    output vid_pkg::vid_bus_s bus,
    input wire logic        oe,
    input wire logic [7:0]  din
);
    initial bus = 3'h7;
    // one transaction, acknowledge or plain, each strobe level held two cycles
    task automatic txn(input logic ack, output logic [8:0] got);
        bus.ack_cycle_n <= !ack;
        bus.addr_strobe_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        bus.addr_strobe_n <= 1'b1;
        repeat (2) @(posedge core_clk);
        bus.data_strobe_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        got = {oe, din};
        bus.data_strobe_n <= 1'b1;
        repeat (2) @(posedge core_clk);
        bus.ack_cycle_n <= 1'b1;
    endtask
endmodule
